// ---- common/regulator_pkg.sv ----
// Constants and types shared by the regulator-enable I2C slave
// Contract
// - Slave only, SCL 400 kHz to 3.4 MHz
// - Selected by 7-bit address plus direction bit
// - Never stretches SCL
// - Works with several masters on the bus
// - One 256-byte space, 8-bit offset
// - Fuses pick address 0x4F, 0x60, 0x74, 0x77
// - Unprogrammed fuses give address 0x4F
// - Read: write offset, repeated start, read
// - Burst reads and writes supported
// - High-speed mode entry after master code
// - Fuse bits load at power-on, stay writable
// - Every register is one byte
// - Write-one-clear bits clear on written one
// - Write-one-act acts; read-only ignores writes
// - Buck enables bits 3..0, reset zero
// - Tracking and linreg 3..0 enables, reset zero
// - Linreg 9..4 and memory rail enables
// - Free regulator follows its enable bit
// - Fuse-assigned enables set at start-up
// - Writing zero turns regulator off anytime
// - Pin-controlled regulator follows selected pin
package regulator_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_FREQ_HZ = 40000000;
  localparam int SCL_FAST_HZ = 400000;
  localparam int SCL_HS_HZ = 3400000;
  localparam int CLK_PER_HS_SCL = CLK_FREQ_HZ / SCL_HS_HZ;
  // ****************************************
  // Addresses and offsets
  // ****************************************
  localparam logic [3:0][6:0] SLAVE_ADDRS = {7'h77, 7'h74, 7'h60, 7'h4f};
  localparam logic [1:0] ADDR_SEL_DEFAULT = 2'h0;
  localparam logic [7:0] OFF_BUCK_ENABLE = 8'h01;
  localparam logic [7:0] OFF_LDO_ENABLE_LOW = 8'h02;
  localparam logic [7:0] OFF_LDO_ENABLE_HIGH = 8'h03;
  localparam logic [7:0] OFF_MEMORY_RAIL_ENABLE = 8'h04;
  localparam logic [7:0] OFF_RAIL_STATUS = 8'hf0;
  localparam logic [7:0] OFF_RAIL_STATE_LO = 8'hf1;
  localparam logic [7:0] OFF_RAIL_STATE_HI = 8'hf2;
  // ****************************************
  // Fields
  // ****************************************
  localparam logic [7:0] MASK_BUCK = 8'h0f;
  localparam logic [7:0] MASK_LDO_LOW = 8'h1f;
  localparam logic [7:0] MASK_LDO_HIGH = 8'h3f;
  localparam logic [7:0] MASK_MEM = 8'h01;
  localparam logic [7:0] RESET_ENABLE = 8'h00;
  localparam int BUCK_BASE = 0;
  localparam int BUCK_COUNT = 4;
  localparam int LDO_LOW_BASE = 4;
  localparam int LDO_LOW_COUNT = 5;
  localparam int LDO_HIGH_BASE = 9;
  localparam int LDO_HIGH_COUNT = 6;
  localparam int MEM_BASE = 15;
  localparam int MEM_COUNT = 1;
  localparam int RAIL_COUNT = 16;
  localparam int STAT_PIN_ON_BIT = 0;
  localparam int STAT_RELOAD_BIT = 1;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ADDR_ACK = 3'h3,
    ST_WR_BYTE = 3'h2,
    ST_WR_ACK = 3'h6,
    ST_RD_BYTE = 3'h7,
    ST_RD_ACK = 3'h5
  } slave_state_t;
  typedef struct packed {
    logic [RAIL_COUNT-1:0] autostart;
    logic [RAIL_COUNT-1:0] pin_ctrl;
    logic [RAIL_COUNT-1:0] pin_sel;
  } rail_fuse_t;
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_t;
endpackage

// ---- test/i2c_master_model.sv ----
// Bit-banged I2C master that drives the slave's bus pins
`timescale 1ns/1ps
module i2c_master_model (
  // Bus pins
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // ****
  // Bus timing, 200 ns SCL period
  // ****
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Low phase longer than high: the slave lets go of SDA only after its filter delay
  task automatic bit_io(input logic b, output logic s);
    #50 sda_low <= ~b;
    #75 scl <= 1'b1;
    #60 s = sda;
    #15 scl <= 1'b0;
  endtask
  // Also a repeated start; SDA is released early so an ACK drive can end first
  task automatic start();
    #50 sda_low <= 1'b0;
    #100 scl <= 1'b1;
    #100 sda_low <= 1'b1;
    #100 scl <= 1'b0;
  endtask
  task automatic stop();
    #50 sda_low <= 1'b1;
    #75 scl <= 1'b1;
    #100 sda_low <= 1'b0;
    #100;
  endtask
  // Sending 8'hff reads a byte; ack_in high means NACK
  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
    output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(tx[i], s);
      rx[i] = s;
    end
    bit_io(ack_in, s);
    ack = ~s;
  endtask
endmodule

// ---- test/testbench.sv ----
// Self-checking bench for the regulator-enable I2C slave
`timescale 1ns/1ps
module testbench;
  // ****
  // Signals
  // ****
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [1:0] addr_fuse = 2'h0;
  // Buck0 and linreg0 start up on; linreg0 is also gated by pin b
  regulator_pkg::rail_fuse_t fuse = {16'h0011, 16'h0010, 16'h0010};
  logic pin_a = 1'b0;
  logic pin_b = 1'b0;
  logic scl;
  logic sda_low;
  logic sda_out;
  logic sda_oe;
  logic [regulator_pkg::RAIL_COUNT-1:0] rail_on;
  logic [7:0] rx;
  logic ack;
  logic [7:0] rd_q [4];
  int bad_count = 0;
  int n_tests = 0;
  // Open-drain line: either party pulls low
  wire sda = ~sda_low & (sda_oe ? sda_out : 1'b1);
  i2c_slave_regulator_enable u_dut (.clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_fuse(addr_fuse), .fuse(fuse),
    .power_enable_pin_a(pin_a), .power_enable_pin_b(pin_b), .rail_on(rail_on));
  i2c_master_model u_master (.scl(scl), .sda_low(sda_low), .sda(sda));
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
      bad_count++;
    end
  endtask
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic do_reset(input logic [1:0] sel);
    @(posedge clk);
    reset <= 1'b1;
    addr_fuse <= sel;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task automatic pins(input logic a, input logic b, input logic [15:0] exp);
    @(posedge clk);
    pin_a <= a;
    pin_b <= b;
    repeat (10) @(posedge clk);
    check("rails vs pins", rail_on, exp);
  endtask
  // Address with write direction, then register offset
  task automatic head(input logic [7:0] off);
    u_master.start();
    u_master.xfer({7'h4f, 1'b0}, 1'b1, rx, ack);
    check("address ack", ack, 1'b1);
    u_master.xfer(off, 1'b1, rx, ack);
    check("offset ack", ack, 1'b1);
  endtask
  // Burst write of n bytes from offset off
  task automatic wr(input logic [7:0] off, input logic [7:0] d [4], input int n);
    head(off);
    for (int i = 0; i < n; i++)
    begin
      u_master.xfer(d[i], 1'b1, rx, ack);
      check("data ack", ack, 1'b1);
    end
    u_master.stop();
  endtask
  // Burst read of four registers from offset off
  task automatic chk_regs(input logic [7:0] off, input logic [7:0] e [4]);
    head(off);
    u_master.start();
    u_master.xfer({7'h4f, 1'b1}, 1'b1, rx, ack);
    check("read address ack", ack, 1'b1);
    for (int i = 0; i < 4; i++)
      u_master.xfer(8'hff, i == 3, rd_q[i], ack);
    u_master.stop();
    for (int i = 0; i < 4; i++)
      check("enable register", rd_q[i], e[i]);
  endtask
  task automatic t_addr();
    for (int i = 0; i < 4; i++)
    begin
      do_reset(i[1:0]);
      for (int k = 0; k < 2; k++)
      begin
        u_master.start();
        u_master.xfer({regulator_pkg::SLAVE_ADDRS[(i + k) % 4], 1'b0}, 1'b1, rx, ack);
        check("address select", ack, k == 0);
        u_master.stop();
      end
    end
    u_master.start();
    u_master.xfer(8'h08, 1'b1, rx, ack);
    check("master code ack", ack, 1'b0);
    u_master.stop();
    do_reset(2'h0);
    $display("Test address selection done");
  endtask
  task automatic t_startup();
    chk_regs(8'h01, '{8'h01, 8'h01, 8'h00, 8'h00});
    check("rails after start-up", rail_on, 16'h0001);
    $display("Test start-up done");
  endtask
  // Every field bit written to one; reserved bits written as zero
  task automatic t_burst();
    wr(8'h01, '{8'h0f, 8'h1f, 8'h3f, 8'h01}, 4);
    chk_regs(8'h01, '{8'h0f, 8'h1f, 8'h3f, 8'h01});
    check("rails, pins low", rail_on, 16'hffef);
    pins(1'b0, 1'b1, 16'hffff);
    pins(1'b1, 1'b0, 16'hffef);
    $display("Test burst write done");
  endtask
  // Pin b turned linreg0 on above, so the sticky flag is set; 0xf3 is unmapped
  task automatic t_status();
    chk_regs(regulator_pkg::OFF_RAIL_STATUS, '{8'h01, 8'hef, 8'hff, 8'h00});
    wr(regulator_pkg::OFF_RAIL_STATUS, '{8'h01, 8'h00, 8'h00, 8'h00}, 3);
    chk_regs(regulator_pkg::OFF_RAIL_STATUS, '{8'h00, 8'hef, 8'hff, 8'h00});
    check("rails after status write", rail_on, 16'hffef);
    $display("Test status register done");
  endtask
  task automatic t_off();
    pins(1'b0, 1'b1, 16'hffff);
    wr(8'h01, '{8'h00, 8'h00, 8'h00, 8'h00}, 4);
    chk_regs(8'h01, '{8'h00, 8'h00, 8'h00, 8'h00});
    check("rails off", rail_on, 16'h0000);
    // Reload action puts the fuse start-up bits back
    wr(regulator_pkg::OFF_RAIL_STATUS, '{8'h02, 8'h00, 8'h00, 8'h00}, 1);
    chk_regs(8'h01, '{8'h01, 8'h01, 8'h00, 8'h00});
    check("rails after reload", rail_on, 16'h0011);
    $display("Test rails off done");
  endtask
  initial
  begin
    do_reset(2'h0);
    t_addr();
    t_startup();
    t_burst();
    t_status();
    t_off();
    end_sim();
  end
  // Cuts a hung run short
  initial
  begin
    #2000000;
    $display("[ERR] run time limit expected end seen none");
    bad_count++;
    end_sim();
  end
endmodule

// ---- verilog/enable_bank.sv ----
// Regulator enable registers and rail control
`timescale 1ns/1ps
module enable_bank (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Fuses and power-enable pins, already filtered
  input regulator_pkg::rail_fuse_t fuse,
  input wire logic pen_a,
  input wire logic pen_b,
  // Register access
  input regulator_pkg::reg_write_t wr,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  // Rail enables
  output logic [regulator_pkg::RAIL_COUNT-1:0] rail_on
);
  logic [7:0] buck;
  logic [7:0] ldo_low;
  logic [7:0] ldo_high;
  logic [7:0] mem;
  logic started;
  logic pin_seen;
  logic [7:0] next_buck;
  logic [7:0] next_ldo_low;
  logic [7:0] next_ldo_high;
  logic [7:0] next_mem;
  logic next_pin_seen;
  logic [regulator_pkg::RAIL_COUNT-1:0] next_rail_on;
  logic [regulator_pkg::RAIL_COUNT-1:0] en_flat;
  logic [regulator_pkg::RAIL_COUNT-1:0] pin_level;
  logic load;
  logic status_wr;

  assign en_flat = {mem[regulator_pkg::MEM_COUNT-1:0],
                    ldo_high[regulator_pkg::LDO_HIGH_COUNT-1:0],
                    ldo_low[regulator_pkg::LDO_LOW_COUNT-1:0],
                    buck[regulator_pkg::BUCK_COUNT-1:0]};
  assign pin_level = (fuse.pin_sel & {regulator_pkg::RAIL_COUNT{pen_b}})
                   | (~fuse.pin_sel & {regulator_pkg::RAIL_COUNT{pen_a}});
  assign status_wr = wr.en && (wr.addr == regulator_pkg::OFF_RAIL_STATUS);
  // Fuse load on the first cycle after reset, or on demand
  assign load = !started || (status_wr && wr.data[regulator_pkg::STAT_RELOAD_BIT]);

  always_comb
  begin
    next_buck = buck;
    next_ldo_low = ldo_low;
    next_ldo_high = ldo_high;
    next_mem = mem;
    if (wr.en)
    begin
      // Unlisted offsets and reserved bits drop the write
      case (wr.addr)
        regulator_pkg::OFF_BUCK_ENABLE: next_buck = wr.data & regulator_pkg::MASK_BUCK;
        regulator_pkg::OFF_LDO_ENABLE_LOW: next_ldo_low = wr.data & regulator_pkg::MASK_LDO_LOW;
        regulator_pkg::OFF_LDO_ENABLE_HIGH: next_ldo_high = wr.data & regulator_pkg::MASK_LDO_HIGH;
        regulator_pkg::OFF_MEMORY_RAIL_ENABLE: next_mem = wr.data & regulator_pkg::MASK_MEM;
        default: next_buck = buck;
      endcase
    end
    if (load)
    begin
      next_buck = next_buck | 8'(fuse.autostart[regulator_pkg::BUCK_BASE +: regulator_pkg::BUCK_COUNT]);
      next_ldo_low = next_ldo_low
        | 8'(fuse.autostart[regulator_pkg::LDO_LOW_BASE +: regulator_pkg::LDO_LOW_COUNT]);
      next_ldo_high = next_ldo_high
        | 8'(fuse.autostart[regulator_pkg::LDO_HIGH_BASE +: regulator_pkg::LDO_HIGH_COUNT]);
      next_mem = next_mem | 8'(fuse.autostart[regulator_pkg::MEM_BASE +: regulator_pkg::MEM_COUNT]);
    end
    // Pin-controlled rails also need their selected pin high
    next_rail_on = en_flat & (~fuse.pin_ctrl | pin_level);
    next_pin_seen = pin_seen;
    if (status_wr && wr.data[regulator_pkg::STAT_PIN_ON_BIT])
    begin
      next_pin_seen = 1'b0;
    end
    // Set beats clear so a pin turn-on in the clear cycle is kept
    if ((next_rail_on & fuse.pin_ctrl & ~rail_on) != '0)
    begin
      next_pin_seen = 1'b1;
    end
  end

  always_comb
  begin
    case (rd_addr)
      regulator_pkg::OFF_BUCK_ENABLE: rd_data = buck;
      regulator_pkg::OFF_LDO_ENABLE_LOW: rd_data = ldo_low;
      regulator_pkg::OFF_LDO_ENABLE_HIGH: rd_data = ldo_high;
      regulator_pkg::OFF_MEMORY_RAIL_ENABLE: rd_data = mem;
      regulator_pkg::OFF_RAIL_STATUS: rd_data = {7'h00, pin_seen};
      regulator_pkg::OFF_RAIL_STATE_LO: rd_data = rail_on[7:0];
      regulator_pkg::OFF_RAIL_STATE_HI: rd_data = rail_on[15:8];
      default: rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      buck <= regulator_pkg::RESET_ENABLE;
      ldo_low <= regulator_pkg::RESET_ENABLE;
      ldo_high <= regulator_pkg::RESET_ENABLE;
      mem <= regulator_pkg::RESET_ENABLE;
      started <= 1'b0;
      pin_seen <= 1'b0;
      rail_on <= '0;
    end
    else
    begin
      buck <= next_buck;
      ldo_low <= next_ldo_low;
      ldo_high <= next_ldo_high;
      mem <= next_mem;
      started <= 1'b1;
      pin_seen <= next_pin_seen;
      rail_on <= next_rail_on;
    end
  end

  default clocking cb @(posedge clk); endclocking
  AST_RESET_BUCK: assert property (reset |=> buck == regulator_pkg::RESET_ENABLE)
    else $error("buck enables not cleared by reset");
  AST_RESET_LDO_LOW: assert property (reset |=> ldo_low == regulator_pkg::RESET_ENABLE)
    else $error("low linreg enables not cleared by reset");
  AST_RESET_HIGH: assert property (reset |=> ldo_high == 8'h00 && mem == 8'h00)
    else $error("high enables not cleared by reset");
  AST_AUTOSTART: assert property (disable iff (reset)
    load |=> (en_flat & $past(fuse.autostart)) == $past(fuse.autostart))
    else $error("fuse-assigned enable not set at start-up");
  AST_WRITE_OFF: assert property (disable iff (reset)
    wr.en && wr.addr == regulator_pkg::OFF_BUCK_ENABLE && !wr.data[0] && !load
    |-> ##2 !rail_on[0])
    else $error("buck 0 still on after zero write");
  AST_DIRECT: assert property (disable iff (reset)
    started |=> ((rail_on ^ $past(en_flat)) & ~$past(fuse.pin_ctrl)) == '0)
    else $error("free rail does not follow its enable bit");
  AST_PIN: assert property (disable iff (reset)
    started |=> (rail_on & $past(fuse.pin_ctrl) & ~$past(pin_level)) == '0)
    else $error("pin-controlled rail on while its pin is low");
  AST_W1C: assert property (disable iff (reset)
    status_wr && wr.data[0] && ((next_rail_on & fuse.pin_ctrl & ~rail_on) == '0)
    |=> !pin_seen)
    else $error("write-one-clear bit not cleared");
  AST_RO: assert property (disable iff (reset)
    wr.en && wr.addr == regulator_pkg::OFF_RAIL_STATE_LO && started |=> $stable(buck))
    else $error("read-only write disturbed an enable");
endmodule

// ---- verilog/i2c_slave_regulator_enable.sv ----
// I2C slave register port driving the regulator enable bank
`timescale 1ns/1ps
module i2c_slave_regulator_enable (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // I2C pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Factory fuses
  input wire logic [1:0] addr_fuse,
  input regulator_pkg::rail_fuse_t fuse,
  // External power-enable pins
  input wire logic power_enable_pin_a,
  input wire logic power_enable_pin_b,
  // Rail enables
  output logic [regulator_pkg::RAIL_COUNT-1:0] rail_on
);
  // ****************************************
  // Declarations
  // ****************************************
  localparam int PIN_COUNT = 4;
  localparam logic [PIN_COUNT-1:0] PIN_IDLE = 4'h3;

  regulator_pkg::slave_state_t state;
  regulator_pkg::slave_state_t next_state;
  regulator_pkg::reg_write_t wr;
  regulator_pkg::reg_write_t next_wr;
  logic [PIN_COUNT-1:0] raw_pins;
  logic [PIN_COUNT-1:0] pins;
  logic scl;
  logic sda;
  logic scl_q;
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [6:0] own_addr;
  logic [6:0] next_own_addr;
  logic addr_loaded;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [7:0] offset;
  logic [7:0] next_offset;
  logic rw;
  logic next_rw;
  logic first;
  logic next_first;
  logic nack;
  logic next_nack;
  logic next_oe;
  logic [7:0] rd_data;
  logic addr_hit;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  assign raw_pins = {power_enable_pin_b, power_enable_pin_a, sda_in, scl_in};

  generate
    for (genvar i = 0; i < PIN_COUNT; i++)
    begin : g_pin
      pin_filter #(
        .RESET_LEVEL(PIN_IDLE[i])
      ) u_filter (
        .clk(clk),
        .reset(reset),
        .raw(raw_pins[i]),
        .level(pins[i])
      );
    end
  endgenerate

  assign scl = pins[0];
  assign sda = pins[1];

  // ****************************************
  // Bus events
  // ****************************************
  // SCL is only ever sampled, so the master's timing is never stretched
  assign scl_rise = scl && !scl_q;
  assign scl_fall = !scl && scl_q;
  // Start and stop are seen in any state, so a second master can cut in
  assign bus_start = scl && scl_q && sda_q && !sda;
  assign bus_stop = scl && scl_q && !sda_q && sda;
  assign addr_hit = (shreg[7:1] == own_addr);
  assign sda_out = 1'b0;

  // ****************************************
  // Address fuse capture
  // ****************************************
  always_comb
  begin
    next_own_addr = own_addr;
    // Captured by the clock after reset release, never by reset itself
    if (!addr_loaded)
    begin
      next_own_addr = regulator_pkg::SLAVE_ADDRS[addr_fuse];
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      own_addr <= regulator_pkg::SLAVE_ADDRS[regulator_pkg::ADDR_SEL_DEFAULT];
      addr_loaded <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      own_addr <= next_own_addr;
      addr_loaded <= 1'b1;
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  // ****************************************
  // Transfer state machine
  // ****************************************
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_shreg = shreg;
    next_offset = offset;
    next_rw = rw;
    next_first = first;
    next_nack = nack;
    next_oe = sda_oe;
    next_wr = '0;
    if (bus_start)
    begin
      // Repeated start keeps the offset for the combined read
      next_state = regulator_pkg::ST_ADDR;
      next_cnt = 4'h0;
      next_first = 1'b1;
      next_oe = 1'b0;
    end
    else if (bus_stop)
    begin
      next_state = regulator_pkg::ST_IDLE;
      next_oe = 1'b0;
    end
    else
    begin
      case (state)
        regulator_pkg::ST_IDLE:
        begin
          next_oe = 1'b0;
        end
        regulator_pkg::ST_ADDR, regulator_pkg::ST_WR_BYTE:
        begin
          if (scl_rise)
          begin
            next_shreg = {shreg[6:0], sda};
            next_cnt = cnt + 4'h1;
          end
          else if (scl_fall && cnt == regulator_pkg::BYTE_BITS)
          begin
            next_cnt = 4'h0;
            if (state == regulator_pkg::ST_ADDR)
            begin
              // A master code or a foreign address is left unanswered
              if (addr_hit)
              begin
                next_state = regulator_pkg::ST_ADDR_ACK;
                next_rw = shreg[0];
                next_oe = 1'b1;
              end
              else
              begin
                next_state = regulator_pkg::ST_IDLE;
              end
            end
            else
            begin
              next_state = regulator_pkg::ST_WR_ACK;
              next_oe = 1'b1;
              next_first = 1'b0;
              if (first)
              begin
                next_offset = shreg;
              end
              else
              begin
                next_wr.en = 1'b1;
                next_wr.addr = offset;
                next_wr.data = shreg;
                next_offset = offset + 8'h01;
              end
            end
          end
        end
        regulator_pkg::ST_ADDR_ACK, regulator_pkg::ST_WR_ACK:
        begin
          if (scl_fall)
          begin
            next_cnt = 4'h0;
            if (state == regulator_pkg::ST_ADDR_ACK && rw)
            begin
              next_state = regulator_pkg::ST_RD_BYTE;
              next_shreg = rd_data;
              next_oe = !rd_data[7];
            end
            else
            begin
              next_state = regulator_pkg::ST_WR_BYTE;
              next_oe = 1'b0;
            end
          end
        end
        regulator_pkg::ST_RD_BYTE:
        begin
          if (scl_fall)
          begin
            if (cnt == regulator_pkg::LAST_BIT)
            begin
              next_state = regulator_pkg::ST_RD_ACK;
              next_oe = 1'b0;
              next_offset = offset + 8'h01;
            end
            else
            begin
              next_shreg = {shreg[6:0], 1'b0};
              next_oe = !shreg[6];
              next_cnt = cnt + 4'h1;
            end
          end
        end
        regulator_pkg::ST_RD_ACK:
        begin
          if (scl_rise)
          begin
            next_nack = sda;
          end
          else if (scl_fall)
          begin
            next_cnt = 4'h0;
            if (nack)
            begin
              next_state = regulator_pkg::ST_IDLE;
            end
            else
            begin
              // Master acked, so the burst continues at the next offset
              next_state = regulator_pkg::ST_RD_BYTE;
              next_shreg = rd_data;
              next_oe = !rd_data[7];
            end
          end
        end
        default:
        begin
          next_state = regulator_pkg::ST_IDLE;
          next_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state <= regulator_pkg::ST_IDLE;
      cnt <= 4'h0;
      shreg <= 8'h00;
      offset <= 8'h00;
      rw <= 1'b0;
      first <= 1'b0;
      nack <= 1'b0;
      sda_oe <= 1'b0;
      wr <= '0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      shreg <= next_shreg;
      offset <= next_offset;
      rw <= next_rw;
      first <= next_first;
      nack <= next_nack;
      sda_oe <= next_oe;
      wr <= next_wr;
    end
  end

  // ****************************************
  // Register bank
  // ****************************************
  enable_bank u_bank (
    .clk(clk),
    .reset(reset),
    .fuse(fuse),
    .pen_a(pins[2]),
    .pen_b(pins[3]),
    .wr(wr),
    .rd_addr(offset),
    .rd_data(rd_data),
    .rail_on(rail_on)
  );

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_ACK_OWN: assert property (state == regulator_pkg::ST_ADDR && scl_fall && !bus_stop
    && cnt == regulator_pkg::BYTE_BITS && addr_hit
    |=> sda_oe && state == regulator_pkg::ST_ADDR_ACK && rw == $past(shreg[0]))
    else $error("own address not acknowledged");
  AST_IGNORE_OTHER: assert property (state == regulator_pkg::ST_ADDR && scl_fall
    && cnt == regulator_pkg::BYTE_BITS && !addr_hit
    |=> state == regulator_pkg::ST_IDLE && !sda_oe)
    else $error("foreign address answered");
  AST_ADDR_SET: assert property (own_addr inside {7'h4f, 7'h60, 7'h74, 7'h77})
    else $error("slave address outside the fuse set");
  AST_DEFAULT_ADDR: assert property (!$past(addr_loaded) && $past(addr_fuse) == 2'h0
    |-> own_addr == 7'h4f)
    else $error("unprogrammed fuses did not give the default address");
  AST_READ_FIRST: assert property (state == regulator_pkg::ST_ADDR_ACK && rw && scl_fall
    && !bus_start && !bus_stop |=> shreg == $past(rd_data))
    else $error("first read byte is not the addressed register");
  AST_READ_STEP: assert property (state == regulator_pkg::ST_RD_BYTE && scl_fall
    && cnt == regulator_pkg::LAST_BIT && !bus_start && !bus_stop
    |=> offset == 8'($past(offset) + 8'h01))
    else $error("offset did not advance after a read byte");
  AST_WRITE_STEP: assert property (wr.en |-> offset == 8'(wr.addr + 8'h01))
    else $error("offset did not advance after a written byte");
  AST_STOP_RELEASE: assert property (bus_stop |=> state == regulator_pkg::ST_IDLE ##1 !sda_oe)
    else $error("slave still holds the bus after a stop");
endmodule

// ---- verilog/pin_filter.sv ----
// Three-flop input synchroniser with agreement filter
`timescale 1ns/1ps
module pin_filter #(
  parameter logic RESET_LEVEL = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Pin in, filtered level out
  input wire logic raw,
  output logic level
);
  logic s1;
  logic s2;
  logic s3;
  logic next_level;

  always_comb
  begin
    next_level = level;
    // First stage is left alone; only stages two and three vote
    if (s2 == s3)
    begin
      next_level = s3;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s1 <= RESET_LEVEL;
      s2 <= RESET_LEVEL;
      s3 <= RESET_LEVEL;
      level <= RESET_LEVEL;
    end
    else
    begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
      level <= next_level;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  AST_FILTER_AGREE: assert property ((s2 == s3) |=> level == $past(s3))
    else $error("filtered level missed an agreed change");
  AST_FILTER_HOLD: assert property ((s2 != s3) |=> $stable(level))
    else $error("filtered level moved without agreement");
endmodule
